// >>> logic/csso_core.sv
// Purpose: executes call, push, pop, sleep, subtract-borrow, branch-if-zero
// Assumes: program memory shows the word at fetch_addr in the same cycle
// Notes: other opcodes act as a one-cycle no-op
`timescale 1ns/1ps
`default_nettype none
module csso_core #(
    parameter int STACK_DEPTH = csso_pkg::STACK_DEPTH_DEF,
    parameter int SPW = $clog2(STACK_DEPTH + 1)
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic instr_valid,
    input wire logic [15:0] instr_word,
    input wire logic wake_req,
    input wire logic [8:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_we,
    input wire logic reg_re,
    output logic [csso_pkg::PC_W-1:0] fetch_addr,
    output logic fetch_ready,
    output logic [7:0] reg_rdata,
    output logic sleep_state,
    output logic osc_enable
);
    // ************************************************************
    // state and decode
    // ************************************************************
    csso_pkg::csso_state_t state_q, state_d;
    logic [20:0] pc_q, pc_d, stk_top, push_data, bz_tgt, call_tgt;
    logic [SPW-1:0] stk_ptr;
    logic [7:0] w_q, status_q, ws_q, fs_q, f_val, ram_b, rd_mux;
    logic [7:0] call_lo_q, wr_data, sub_res;
    logic [3:0] bsr_q, bs_q, post_q;
    logic [7:0] wdt_q;
    logic [8:0] sub_full;
    logic [4:0] sub_lo;
    logic [7:0] wr_addr;
    logic fetch_ready_q, sleep_q, osc_q, to_q, pd_q;
    logic take, run_take, call2_take, bz_taken, wdt_ovf, carry_in;
    logic is_bz, is_call, is_pop, is_push, is_sleep, is_sub;
    logic sub_to_w, sub_to_f, core_wr, bus_wr_ram, push_en, pop_en;

    generate
        if (STACK_DEPTH < 2 || STACK_DEPTH > 255) begin : g_bad
            $error("csso_core: STACK_DEPTH must be 2 to 255");
        end
    endgenerate

    // a word is taken only while the core asks for one
    assign take = ce && instr_valid && fetch_ready_q;
    assign run_take = take && state_q == csso_pkg::CSSO_RUN;
    assign call2_take = take && state_q == csso_pkg::CSSO_CALL2;

    // opcode match on the fetched word
    assign is_bz = instr_word[15:8] == csso_pkg::OP_BZ_HI;
    assign is_call = instr_word[15:9] == csso_pkg::OP_CALL_HI;
    assign is_pop = instr_word == csso_pkg::OP_POP;
    assign is_push = instr_word == csso_pkg::OP_PUSH;
    assign is_sleep = instr_word == csso_pkg::OP_SLEEP;
    assign is_sub = instr_word[15:10] == csso_pkg::OP_SUB_HI;

    assign carry_in = status_q[csso_pkg::ST_C];
    assign bz_taken = run_take && is_bz && status_q[csso_pkg::ST_Z];
    assign wdt_ovf = wdt_q == csso_pkg::WDT_MAX
        && post_q == csso_pkg::POST_MAX;

    // next state of the sequencer
    always_comb begin
        state_d = state_q;
        case (state_q)
            csso_pkg::CSSO_RUN: begin
                if (run_take && is_call) begin
                    state_d = csso_pkg::CSSO_CALL2;
                end else if (bz_taken) begin
                    state_d = csso_pkg::CSSO_FLUSH;
                end else if (run_take && is_sleep) begin
                    state_d = csso_pkg::CSSO_SLEEP;
                end
            end
            csso_pkg::CSSO_CALL2: begin
                if (call2_take) begin
                    state_d = csso_pkg::CSSO_RUN;
                end
            end
            csso_pkg::CSSO_FLUSH: begin
                state_d = csso_pkg::CSSO_RUN;
            end
            csso_pkg::CSSO_SLEEP: begin
                if (wake_req || wdt_ovf) begin
                    state_d = csso_pkg::CSSO_RUN;
                end
            end
            default: begin
                state_d = csso_pkg::CSSO_RUN;
            end
        endcase
    end

    // sequencer state and the flags it drives out
    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= csso_pkg::CSSO_RUN;
            fetch_ready_q <= 1'b1;
            sleep_q <= 1'b0;
            osc_q <= 1'b1;
        end else if (ce) begin
            state_q <= state_d;
            fetch_ready_q <= state_d == csso_pkg::CSSO_RUN
                || state_d == csso_pkg::CSSO_CALL2;
            sleep_q <= state_d == csso_pkg::CSSO_SLEEP;
            osc_q <= state_d != csso_pkg::CSSO_SLEEP;
        end
    end

    // ************************************************************
    // program counter and return stack
    // ************************************************************
    assign bz_tgt = pc_q + csso_pkg::PC_STEP
        + {{12{instr_word[7]}}, instr_word[7:0], 1'b0};
    assign call_tgt = {instr_word[11:0], call_lo_q, 1'b0};

    // next fetch address
    always_comb begin
        pc_d = pc_q;
        if (bz_taken) begin
            pc_d = bz_tgt;
        end else if (run_take) begin
            pc_d = pc_q + csso_pkg::PC_STEP;
        end else if (call2_take) begin
            pc_d = call_tgt;
        end
    end

    // program counter and low literal of a call
    always_ff @(posedge clk) begin
        if (rst) begin
            pc_q <= csso_pkg::PC_RST;
            call_lo_q <= 8'h00;
        end else if (ce) begin
            pc_q <= pc_d;
            if (run_take && is_call) begin
                call_lo_q <= instr_word[7:0];
            end
        end
    end

    // stack requests from call, push and pop
    assign push_en = run_take && (is_call || is_push);
    assign pop_en = run_take && is_pop;
    assign push_data = is_call ? pc_q + csso_pkg::CALL_RET_OFS
        : pc_q + csso_pkg::PC_STEP;

    csso_stack #(
        .DEPTH(STACK_DEPTH),
        .W(csso_pkg::PC_W),
        .PW(SPW)
    ) u_stack (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .push(push_en),
        .pop(pop_en),
        .push_data(push_data),
        .top(stk_top),
        .ptr(stk_ptr)
    );

    // ************************************************************
    // subtract with borrow and data registers
    // ************************************************************
    assign sub_full = {1'b0, w_q} - {1'b0, f_val}
        - {8'h00, ~carry_in};
    assign sub_lo = {1'b0, w_q[3:0]} - {1'b0, f_val[3:0]}
        - {4'h0, ~carry_in};
    assign sub_res = sub_full[7:0];
    assign sub_to_w = run_take && is_sub && !instr_word[csso_pkg::SUB_D_BIT];
    assign sub_to_f = run_take && is_sub && instr_word[csso_pkg::SUB_D_BIT];

    // core write beats a same-cycle register-port write
    assign bus_wr_ram = reg_we && !reg_addr[8];
    assign core_wr = sub_to_f || bus_wr_ram;
    assign wr_addr = sub_to_f ? instr_word[7:0] : reg_addr[7:0];
    assign wr_data = sub_to_f ? sub_res : reg_wdata;

    csso_file_ram u_ram (
        .clk(clk),
        .ce(ce),
        .wr_en(core_wr),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .rd_addr_a(instr_word[7:0]),
        .rd_data_a(f_val),
        .rd_addr_b(reg_addr[7:0]),
        .rd_data_b(ram_b)
    );

    // working, status and bank registers
    always_ff @(posedge clk) begin
        if (rst) begin
            w_q <= csso_pkg::W_RST;
            status_q <= csso_pkg::STATUS_RST;
            bsr_q <= csso_pkg::BSR_RST;
        end else if (ce) begin
            if (sub_to_w) begin
                w_q <= sub_res;
            end else if (reg_we && reg_addr == csso_pkg::ADDR_W) begin
                w_q <= reg_wdata;
            end
            if (run_take && is_sub) begin
                status_q <= {status_q[7:5], sub_res[7],
                    (w_q[7] != f_val[7]) && (sub_res[7] != w_q[7]),
                    sub_res == 8'h00, ~sub_lo[4], ~sub_full[8]};
            end else if (reg_we && reg_addr == csso_pkg::ADDR_STATUS) begin
                status_q <= reg_wdata;
            end
            if (reg_we && reg_addr == csso_pkg::ADDR_BSR) begin
                bsr_q <= reg_wdata[3:0];
            end
        end
    end

    // shadow copies taken by a call when asked
    always_ff @(posedge clk) begin
        if (rst) begin
            ws_q <= csso_pkg::W_RST;
            fs_q <= csso_pkg::STATUS_RST;
            bs_q <= csso_pkg::BSR_RST;
        end else if (ce && run_take && is_call
            && instr_word[csso_pkg::CALL_S_BIT]) begin
            ws_q <= w_q;
            fs_q <= status_q;
            bs_q <= bsr_q;
        end
    end

    // ************************************************************
    // sleep, power flags and watchdog
    // ************************************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            to_q <= csso_pkg::TO_RST;
            pd_q <= csso_pkg::PD_RST;
        end else if (ce) begin
            if (run_take && is_sleep) begin
                pd_q <= 1'b0;
                to_q <= 1'b1;
            end else if (state_q == csso_pkg::CSSO_SLEEP && wdt_ovf) begin
                to_q <= 1'b0; // watchdog wake
            end
        end
    end

    // watchdog counter with postscaler behind it
    always_ff @(posedge clk) begin
        if (rst) begin
            wdt_q <= csso_pkg::WDT_CLR;
            post_q <= csso_pkg::POST_CLR;
        end else if (ce) begin
            if (run_take && is_sleep) begin
                wdt_q <= csso_pkg::WDT_CLR;
                post_q <= csso_pkg::POST_CLR;
            end else begin
                wdt_q <= wdt_q + 1'b1;
                if (wdt_q == csso_pkg::WDT_MAX) begin
                    post_q <= post_q + 1'b1;
                end
            end
        end
    end

    // ************************************************************
    // register port read
    // ************************************************************
    always_comb begin
        rd_mux = 8'h00;
        if (!reg_addr[8]) begin
            rd_mux = ram_b;
        end else begin
            case (reg_addr)
                csso_pkg::ADDR_W: rd_mux = w_q;
                csso_pkg::ADDR_STATUS: rd_mux = status_q;
                csso_pkg::ADDR_BSR: rd_mux = {4'h0, bsr_q};
                csso_pkg::ADDR_WSHD: rd_mux = ws_q;
                csso_pkg::ADDR_FSHD: rd_mux = fs_q;
                csso_pkg::ADDR_BSHD: rd_mux = {4'h0, bs_q};
                csso_pkg::ADDR_PWR: rd_mux = {4'h0, to_q, pd_q, 2'h0};
                csso_pkg::ADDR_TOSL: rd_mux = stk_top[7:0];
                csso_pkg::ADDR_TOSH: rd_mux = stk_top[15:8];
                csso_pkg::ADDR_TOSU: rd_mux = {3'h0, stk_top[20:16]};
                csso_pkg::ADDR_SP: rd_mux = 8'(stk_ptr);
                csso_pkg::ADDR_PCL: rd_mux = pc_q[7:0];
                csso_pkg::ADDR_PCH: rd_mux = pc_q[15:8];
                csso_pkg::ADDR_PCU: rd_mux = {3'h0, pc_q[20:16]};
                default: rd_mux = 8'h00;
            endcase
        end
    end

    // read data stands one cycle, zero otherwise
    always_ff @(posedge clk) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (ce) begin
            reg_rdata <= reg_re ? rd_mux : 8'h00;
        end
    end

    assign fetch_addr = pc_q;
    assign fetch_ready = fetch_ready_q;
    assign sleep_state = sleep_q;
    assign osc_enable = osc_q;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    AST_CALL_SHADOW: assert property (
        run_take && is_call && instr_word[csso_pkg::CALL_S_BIT]
        |=> ws_q == $past(w_q) && fs_q == $past(status_q)
            && bs_q == $past(bsr_q))
        else $error("call did not fill shadows");
    AST_CALL_NOSHADOW: assert property (
        run_take && is_call && !instr_word[csso_pkg::CALL_S_BIT]
        |=> $stable(ws_q) && $stable(fs_q) && $stable(bs_q))
        else $error("call without shadow touched shadows");
    AST_CALL_PUSH: assert property (
        run_take && is_call && stk_ptr != SPW'(STACK_DEPTH)
        |=> stk_top == $past(pc_q) + csso_pkg::CALL_RET_OFS
            && state_q == csso_pkg::CSSO_CALL2)
        else $error("call pushed wrong return address");
    AST_CALL_TARGET: assert property (
        call2_take |=> pc_q == $past(call_tgt) && pc_q[0] == 1'b0
            && state_q == csso_pkg::CSSO_RUN)
        else $error("call target not loaded");
    AST_SLEEP_PD: assert property (
        run_take && is_sleep |=> !pd_q)
        else $error("sleep left power-down flag set");
    AST_SLEEP_TO: assert property (
        run_take && is_sleep |=> to_q)
        else $error("sleep did not set time-out flag");
    AST_SLEEP_WDT: assert property (
        run_take && is_sleep |=> wdt_q == csso_pkg::WDT_CLR
            && post_q == csso_pkg::POST_CLR && sleep_state && !osc_enable
            && !fetch_ready)
        else $error("sleep entry incomplete");
    AST_SUB_W: assert property (
        sub_to_w |=> 8'(w_q + $past(f_val) + {7'h00, ~$past(carry_in)})
            == $past(w_q))
        else $error("subtract-borrow result wrong");
    AST_SUB_F: assert property (
        sub_to_f && !(reg_we && reg_addr == csso_pkg::ADDR_W)
        |=> w_q == $past(w_q))
        else $error("file destination changed working register");
    AST_POP_FLAGS: assert property (
        pop_en && !(reg_we && reg_addr == csso_pkg::ADDR_STATUS)
        |=> $stable(status_q) && fetch_ready)
        else $error("pop disturbed flags or stalled");
    AST_BZ_TAKEN: assert property (
        bz_taken |=> pc_q == $past(bz_tgt) && !fetch_ready)
        else $error("taken branch wrong");
    AST_BZ_FALL: assert property (
        run_take && is_bz && !status_q[csso_pkg::ST_Z]
        |=> pc_q == $past(pc_q) + csso_pkg::PC_STEP && fetch_ready)
        else $error("untaken branch wrong");
endmodule : csso_core
`default_nettype wire

// >>> common/csso_pkg.sv
// Purpose: shared constants and types for the call/stack/sleep/subtract core
// Assumes: 8-bit data path, 21-bit byte program counter
// Notes: all offsets and opcodes live here, and the reset values of pc, w, status, bsr, shadows, to, pd and watchdog
package csso_pkg;
    // ************************************************************
    // widths and program counter steps
    // ************************************************************
    localparam int PC_W = 21;
    localparam int STACK_DEPTH_DEF = 31;
    localparam logic [20:0] PC_RST = 21'h000000;
    localparam logic [20:0] PC_STEP = 21'h000002;
    localparam logic [20:0] CALL_RET_OFS = 21'h000004;

    // ************************************************************
    // opcodes and operand bit positions
    // ************************************************************
    localparam logic [15:0] OP_SLEEP = 16'h0003;
    localparam logic [15:0] OP_PUSH = 16'h0005;
    localparam logic [15:0] OP_POP = 16'h0006;
    localparam logic [7:0] OP_BZ_HI = 8'hE0;
    localparam logic [6:0] OP_CALL_HI = 7'h76;
    localparam logic [5:0] OP_SUB_HI = 6'h15;
    localparam int CALL_S_BIT = 8;
    localparam int SUB_D_BIT = 9;

    // ************************************************************
    // flag positions and reset values
    // ************************************************************
    localparam int ST_C = 0;
    localparam int ST_DC = 1;
    localparam int ST_Z = 2;
    localparam int ST_OV = 3;
    localparam int ST_N = 4;
    localparam int PWR_PD = 2;
    localparam int PWR_TO = 3;
    localparam logic [7:0] W_RST = 8'h00;
    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam logic [3:0] BSR_RST = 4'h0;
    localparam logic TO_RST = 1'b1;
    localparam logic PD_RST = 1'b1;
    localparam logic [7:0] WDT_CLR = 8'h00;
    localparam logic [7:0] WDT_MAX = 8'hFF;
    localparam logic [3:0] POST_CLR = 4'h0;
    localparam logic [3:0] POST_MAX = 4'hF;

    // ************************************************************
    // register port map
    // ************************************************************
    localparam logic [8:0] ADDR_W = 9'h100;
    localparam logic [8:0] ADDR_STATUS = 9'h101;
    localparam logic [8:0] ADDR_BSR = 9'h102;
    localparam logic [8:0] ADDR_WSHD = 9'h103;
    localparam logic [8:0] ADDR_FSHD = 9'h104;
    localparam logic [8:0] ADDR_BSHD = 9'h105;
    localparam logic [8:0] ADDR_PWR = 9'h106;
    localparam logic [8:0] ADDR_TOSL = 9'h107;
    localparam logic [8:0] ADDR_TOSH = 9'h108;
    localparam logic [8:0] ADDR_TOSU = 9'h109;
    localparam logic [8:0] ADDR_SP = 9'h10A;
    localparam logic [8:0] ADDR_PCL = 9'h10B;
    localparam logic [8:0] ADDR_PCH = 9'h10C;
    localparam logic [8:0] ADDR_PCU = 9'h10D;

    typedef enum logic [1:0] {
        CSSO_RUN,
        CSSO_CALL2,
        CSSO_FLUSH,
        CSSO_SLEEP
    } csso_state_t;
endpackage : csso_pkg

// >>> logic/csso_file_ram.sv
// Purpose: 256-byte file register array, one write and two read ports
// Assumes: reads are combinational, writes land at the clock edge
// Notes: contents are data and carry no reset
`timescale 1ns/1ps
`default_nettype none
module csso_file_ram (
    input wire logic clk,
    input wire logic ce,
    input wire logic wr_en,
    input wire logic [7:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic [7:0] rd_addr_a,
    output logic [7:0] rd_data_a,
    input wire logic [7:0] rd_addr_b,
    output logic [7:0] rd_data_b
);
    logic [7:0] mem [0:255];

    // write port, frozen with the clock enable
    always_ff @(posedge clk) begin
        if (ce && wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // execution read and register-port read
    assign rd_data_a = mem[rd_addr_a];
    assign rd_data_b = mem[rd_addr_b];
endmodule : csso_file_ram
`default_nettype wire

// >>> logic/csso_stack.sv
// Purpose: hardware return stack with push, pop and a visible top
// Assumes: push and pop never requested in the same cycle
// Notes: push when full and pop when empty are ignored
`timescale 1ns/1ps
`default_nettype none
module csso_stack #(
    parameter int DEPTH = 31,
    parameter int W = 21,
    parameter int PW = $clog2(DEPTH + 1)
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic push,
    input wire logic pop,
    input wire logic [W-1:0] push_data,
    output logic [W-1:0] top,
    output logic [PW-1:0] ptr
);
    localparam logic [PW-1:0] FULL = PW'(DEPTH);
    logic [W-1:0] ent [0:DEPTH-1];
    logic [PW-1:0] ptr_q;
    logic [W-1:0] below_top;

    generate
        if (DEPTH < 2 || W < 1) begin : g_bad
            $error("csso_stack: DEPTH must be at least 2");
        end
    endgenerate

    // pointer counts live entries
    always_ff @(posedge clk) begin
        if (rst) begin
            ptr_q <= '0;
        end else if (ce) begin
            if (push && ptr_q != FULL) begin
                ptr_q <= ptr_q + 1'b1;
            end else if (pop && ptr_q != '0) begin
                ptr_q <= ptr_q - 1'b1;
            end
        end
    end

    // entry storage, written at the free slot
    always_ff @(posedge clk) begin
        if (ce && push && ptr_q != FULL) begin
            ent[ptr_q] <= push_data;
        end
    end

    // top of stack reads zero when empty
    assign top = (ptr_q == '0) ? '0 : ent[ptr_q - 1'b1];
    assign ptr = ptr_q;

    // entry under the top, what a pop has to expose next
    assign below_top = (ptr_q < 2) ? '0 : ent[ptr_q - 2'd2];

    // ************************************************************
    // checks
    // ************************************************************
    AST_PUSH_TOP: assert property (@(posedge clk) disable iff (rst)
        ce && push && ptr_q != FULL |=> top == $past(push_data)
            && ptr_q == $past(ptr_q) + 1'b1)
        else $error("push did not place data on top");
    AST_POP_PTR: assert property (@(posedge clk) disable iff (rst)
        ce && pop && ptr_q > 1 |=> ptr_q == $past(ptr_q) - 1'b1
            && top == $past(below_top))
        else $error("pop did not expose previous entry");
endmodule : csso_stack
`default_nettype wire

// >>> tb/csso_prog_mem.sv
// Purpose: program memory model feeding instruction words to the core
// Assumes: the word follows fetch_addr combinationally
// Notes: slow mode withholds every other cycle; beyond the program all nops
`timescale 1ns/1ps
`default_nettype none
module csso_prog_mem (
    input wire logic clk,
    input wire logic stall,
    input wire logic slow,
    input wire logic [20:0] fetch_addr,
    output logic instr_valid,
    output logic [15:0] instr_word
);
    logic ph_q = 1'b0;
    logic [15:0] rom_word;
    // phase for slow answers and for the idle pattern
    always_ff @(posedge clk) begin
        ph_q <= ~ph_q;
    end
    // fixed program: subtracts, calls, push, pop, branches, sleep
    always_comb begin
        case (fetch_addr)
            21'h00, 21'h24: rom_word = 16'h5410;
            21'h02: rom_word = 16'h5611;
            21'h04: rom_word = 16'hED10;
            21'h06, 21'h28: rom_word = 16'hF000;
            21'h20: rom_word = 16'h0005;
            21'h22: rom_word = 16'h0006;
            21'h26: rom_word = 16'hEC18;
            21'h30, 21'h34: rom_word = 16'hE002;
            21'h32: rom_word = 16'h5412;
            21'h36, 21'h38: rom_word = 16'h5413; // trap if branch misbehaves
            21'h3A: rom_word = 16'h0003;
            default: rom_word = 16'h0000;
        endcase
    end
    // withheld words alternate between the inverted word and the true word while stalled; slow-mode gaps show the inverted word
    assign instr_valid = ~stall & (~slow | ph_q);
    assign instr_word = instr_valid ? rom_word : ~rom_word ^ {16{ph_q}};
endmodule : csso_prog_mem
`default_nettype wire

// >>> tb/tb_csso_core.sv
// Purpose: self-checking bench for the instruction core
// Assumes: registers reached over the plain register port
// Notes: runs one program to sleep, checks state, then wakes the core
`timescale 1ns/1ps
`default_nettype none
module tb_csso_core;
    logic clk = 1'b0, rst = 1'b1, ce = 1'b1, wake_req = 1'b0;
    logic reg_we = 1'b0, reg_re = 1'b0, stall = 1'b1, slow = 1'b1;
    logic [8:0] reg_addr = 9'h000;
    logic [7:0] reg_wdata = 8'h00, reg_rdata;
    logic instr_valid, fetch_ready, sleep_state, osc_enable;
    logic [15:0] instr_word;
    logic [20:0] fetch_addr;
    int err_total = 0, checked = 0, cyc = 0;
    always #10 clk = ~clk;
    csso_core u_csso_core (.clk(clk), .rst(rst), .ce(ce),
        .instr_valid(instr_valid), .instr_word(instr_word),
        .wake_req(wake_req), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_we(reg_we), .reg_re(reg_re), .fetch_addr(fetch_addr),
        .fetch_ready(fetch_ready), .reg_rdata(reg_rdata),
        .sleep_state(sleep_state), .osc_enable(osc_enable));
    csso_prog_mem u_csso_prog_mem (.clk(clk), .stall(stall), .slow(slow),
        .fetch_addr(fetch_addr), .instr_valid(instr_valid),
        .instr_word(instr_word));
    // ************************************************************
    // report, compares and register port tasks
    // ************************************************************
    task automatic results;
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : results
    task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask : chk8
    task automatic chk1(input string nm, input logic e, input logic g);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH %s exp %b got %b", nm, e, g);
        end
    endtask : chk1
    task automatic wr(input logic [8:0] a, input logic [7:0] v);
        @(posedge clk);
        reg_we <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_we <= 1'b0;
    endtask : wr
    task automatic rdc(input string nm, input logic [8:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_re <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_re <= 1'b0;
        #1 chk8(nm, e, reg_rdata);
    endtask : rdc
    // wait until the sleep output reaches lvl, at most lim cycles
    task automatic wait_sleep(input logic lvl, input int lim);
        int k;
        k = 0;
        while (sleep_state !== lvl && k < lim) begin
            @(posedge clk);
            #1 k++;
        end
    endtask : wait_sleep
    // cycle ceiling against hangs
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            results();
        end
    end
    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        rdc("pwr_rst", 9'h106, 8'h0C);
        wr(9'h100, 8'h03);
        wr(9'h101, 8'h01);
        wr(9'h102, 8'h05);
        wr(9'h010, 8'h02);
        wr(9'h011, 8'h05);
        wr(9'h012, 8'hFD);
        wr(9'h013, 8'h77);
        wr(9'h103, 8'hAA);
        @(posedge clk);
        stall <= 1'b0;
        wait_sleep(1'b1, 400);
        chk1("sleep_state", 1'b1, sleep_state);
        chk1("osc_enable", 1'b0, osc_enable);
        chk1("fetch_ready", 1'b0, fetch_ready);
        chk8("fetch_addr", 8'h3C, fetch_addr[7:0]);
        rdc("w", 9'h100, 8'h00);
        rdc("status", 9'h101, 8'h07);
        rdc("file10", 9'h010, 8'h02);
        rdc("file11", 9'h011, 8'hFC);
        rdc("w_shadow", 9'h103, 8'h01);
        rdc("flags_shadow", 9'h104, 8'h10);
        rdc("bank_shadow", 9'h105, 8'h05);
        rdc("stack_ptr", 9'h10A, 8'h02);
        rdc("stack_top", 9'h107, 8'h2A);
        rdc("pwr", 9'h106, 8'h08);
        rdc("unmapped", 9'h1FF, 8'h00);
        // a low clock enable keeps the core asleep despite a wake request
        @(posedge clk);
        ce <= 1'b0;
        wake_req <= 1'b1;
        repeat (3) @(posedge clk);
        #1 chk1("sleep_frozen", 1'b1, sleep_state);
        @(posedge clk);
        ce <= 1'b1;
        wait_sleep(1'b0, 10);
        chk1("sleep_state_wake", 1'b0, sleep_state);
        chk1("osc_enable_wake", 1'b1, osc_enable);
        // reset in mid-run, then the same program with no wait states
        @(posedge clk);
        wake_req <= 1'b0;
        rst <= 1'b1;
        stall <= 1'b1;
        slow <= 1'b0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1 chk1("fetch_ready_rst", 1'b1, fetch_ready);
        chk8("fetch_addr_rst", 8'h00, fetch_addr[7:0]);
        chk1("sleep_state_rst", 1'b0, sleep_state);
        rdc("pwr_rst2", 9'h106, 8'h0C);
        rdc("stack_ptr_rst", 9'h10A, 8'h00);
        wr(9'h100, 8'h03);
        wr(9'h101, 8'h01);
        wr(9'h102, 8'h09);
        wr(9'h011, 8'h05);
        @(posedge clk);
        stall <= 1'b0;
        wait_sleep(1'b1, 400);
        chk1("sleep_state2", 1'b1, sleep_state);
        rdc("w2", 9'h100, 8'h00);
        rdc("status2", 9'h101, 8'h07);
        rdc("bank_shadow2", 9'h105, 8'h09);
        rdc("stack_ptr2", 9'h10A, 8'h02);
        rdc("pwr2", 9'h106, 8'h08);
        // no wake request: the watchdog ends the sleep and clears time-out
        wait_sleep(1'b0, 4200);
        chk1("sleep_state_wdt", 1'b0, sleep_state);
        rdc("pwr_wdt", 9'h106, 8'h00);
        results();
    end
endmodule : tb_csso_core
`default_nettype wire
